// *** src/swk_cfg_pkg.sv ***
// Constants, field layouts and carrier types for the selective wake configuration registers.
// Assumes a byte-wide register port with seven-bit addresses.
package swk_cfg_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	localparam logic [6:0] OFFS_PAYLOAD_TWO  = 7'h31;
	localparam logic [6:0] OFFS_PAYLOAD_ONE  = 7'h32;
	localparam logic [6:0] OFFS_PAYLOAD_ZERO = 7'h33;
	localparam logic [6:0] OFFS_FAST_RATE    = 7'h34;
	localparam logic [6:0] OFFS_FINE_TRIM    = 7'h38;
	localparam logic [6:0] OFFS_OPTIONS      = 7'h39;

	localparam logic [7:0] RESET_PAYLOAD   = 8'h00;
	localparam logic [7:0] RESET_FAST_RATE = 8'h00;
	// Trim resets are undefined in the device; these defaults are a plain mid value.
	localparam logic [7:0] RESET_FINE_TRIM = 8'h10;
	localparam logic [4:0] RESET_COARSE    = 5'h10;

	localparam int TOL_EN_BIT     = 0;
	localparam int FILT_LSB       = 1;
	localparam int FILT_MSB       = 3;
	localparam int BYPASS_BIT     = 4;
	localparam int ERR_DIS_BIT    = 5;
	localparam int COARSE_MSB     = 4;
	localparam int RX_SEL_BIT     = 7;
	localparam int FINE_MSB       = 4;

	localparam logic [1:0] TRIM_UNLOCK = 2'h3;
	localparam logic [2:0] FILT_LONG_CODE = 3'h7;

	// Dominant filter times and clock period in ns.
	localparam int FILT_STEP_NS = 50;
	localparam int FILT_LONG_NS = 387;
	localparam int CLK_PERIOD_NS = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_type;

	typedef struct packed {
		logic       tolerantModeEnable;
		logic [2:0] dominantFilterTime;
		logic       analogFilterBypass;
		logic       errorCounterDisable;
	} fast_rate_type;
endpackage : swk_cfg_pkg

// *** src/filter_time_decode.sv ***
// Converts the dominant filter time code to nanoseconds and to clock cycles.
// Assumes the clock period constant of the package.
`timescale 1ns/1ps
module filter_time_decode
	import swk_cfg_pkg::*;
(
	input  wire logic [2:0] code,
	output logic      [8:0] timeNs,
	output logic      [6:0] timeCycles
);
	logic [8:0] ns;

	always_comb begin
		if (code == FILT_LONG_CODE) begin
			ns = 9'(FILT_LONG_NS);
		end else begin
			ns = 9'((int'(code) + 1) * FILT_STEP_NS);
		end
	end

	// A least time rounds up to whole cycles.
	assign timeNs     = ns;
	assign timeCycles = 7'((int'(ns) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endmodule : filter_time_decode

// *** src/selective_wake_config_regs.sv ***
// Selective wake configuration registers: payload bytes, tolerance and trim.
// Assumes a synchronous byte port where read data stand in the cycle after the read strobe.
//
// Behaviour
// - Three payload bytes, full eight bits each.
// - Reserved bits read zero, writes ignored.
// - Bit 0 enables tolerant mode, resets zero.
// - Filter code steps 50 ns, top 387.
// - Bit 4 bypasses analog filter only.
// - Bit 5 stops error counter in selective wake if tolerant.
// - Silence timeout clears error counter disable.
// - Trim writes only with key 11.
// - Fine trim bits 0-4, monotonic steps.
// - Options bits 4-0 hold coarse trim.
// - Bit 7 picks wake receiver, keyed.
`timescale 1ns/1ps
module selective_wake_config_regs
	import swk_cfg_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire swk_cfg_pkg::reg_req_type  regReq,
	output logic      [DATA_W-1:0]         rdata,
	input  wire logic [1:0]                trimEnable,
	input  wire logic                      silenceTimeout,
	input  wire logic                      selectiveWakeActive,
	output swk_cfg_pkg::fast_rate_type     fastRate,
	output logic                           errorCounterRun,
	output logic                           analogFilterBypass,
	output logic                           digitalFilterActive,
	output logic      [8:0]                dominantFilterNs,
	output logic      [6:0]                dominantFilterCycles,
	output logic      [12:0]               oscillatorTrim,
	output logic      [4:0]                fineTrimStep,
	output logic                           wakeReceiverSelect,
	output logic      [23:0]               referencePayload
);
	logic [7:0]    payloadTwo_q;
	logic [7:0]    payloadTwo_d;
	logic [7:0]    payloadOne_q;
	logic [7:0]    payloadOne_d;
	logic [7:0]    payloadZero_q;
	logic [7:0]    payloadZero_d;
	fast_rate_type fastRate_q;
	fast_rate_type fastRate_d;
	logic [7:0]    fineTrim_q;
	logic [7:0]    fineTrim_d;
	logic [4:0]    coarseTrim_q;
	logic [4:0]    coarseTrim_d;
	logic          rxSelect_q;
	logic          rxSelect_d;
	logic [7:0]    rdata_q;
	logic [7:0]    rdata_d;
	logic          trimUnlocked;
	logic          writeHit;

	assign trimUnlocked = (trimEnable == TRIM_UNLOCK);
	assign writeHit     = regReq.wr;

	// Register writes.
	always_comb begin
		payloadTwo_d  = payloadTwo_q;
		payloadOne_d  = payloadOne_q;
		payloadZero_d = payloadZero_q;
		fastRate_d    = fastRate_q;
		fineTrim_d    = fineTrim_q;
		coarseTrim_d  = coarseTrim_q;
		rxSelect_d    = rxSelect_q;
		if (writeHit) begin
			case (regReq.addr)
				OFFS_PAYLOAD_TWO: begin
					payloadTwo_d = regReq.wdata;
				end
				OFFS_PAYLOAD_ONE: begin
					payloadOne_d = regReq.wdata;
				end
				OFFS_PAYLOAD_ZERO: begin
					payloadZero_d = regReq.wdata;
				end
				OFFS_FAST_RATE: begin
					// Bits 7:6 are not stored at all.
					fastRate_d.tolerantModeEnable  = regReq.wdata[TOL_EN_BIT];
					fastRate_d.dominantFilterTime  = regReq.wdata[FILT_MSB:FILT_LSB];
					fastRate_d.analogFilterBypass  = regReq.wdata[BYPASS_BIT];
					fastRate_d.errorCounterDisable = regReq.wdata[ERR_DIS_BIT];
				end
				OFFS_FINE_TRIM: begin
					if (trimUnlocked) begin
						fineTrim_d = regReq.wdata;
					end
				end
				OFFS_OPTIONS: begin
					if (trimUnlocked) begin
						coarseTrim_d = regReq.wdata[COARSE_MSB:0];
						rxSelect_d   = regReq.wdata[RX_SEL_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		// The hardware clear is applied last so it beats a simultaneous write of one.
		if (silenceTimeout) begin
			fastRate_d.errorCounterDisable = 1'b0;
		end
	end

	// Read data; reserved and unmapped bits return zero.
	always_comb begin
		rdata_d = 8'h00;
		if (regReq.rd) begin
			case (regReq.addr)
				OFFS_PAYLOAD_TWO: begin
					rdata_d = payloadTwo_q;
				end
				OFFS_PAYLOAD_ONE: begin
					rdata_d = payloadOne_q;
				end
				OFFS_PAYLOAD_ZERO: begin
					rdata_d = payloadZero_q;
				end
				OFFS_FAST_RATE: begin
					rdata_d[TOL_EN_BIT]         = fastRate_q.tolerantModeEnable;
					rdata_d[FILT_MSB:FILT_LSB]  = fastRate_q.dominantFilterTime;
					rdata_d[BYPASS_BIT]         = fastRate_q.analogFilterBypass;
					rdata_d[ERR_DIS_BIT]        = fastRate_q.errorCounterDisable;
				end
				OFFS_FINE_TRIM: begin
					rdata_d = fineTrim_q;
				end
				OFFS_OPTIONS: begin
					rdata_d[COARSE_MSB:0] = coarseTrim_q;
					// The receiver select is only visible while the key is set.
					if (trimUnlocked) begin
						rdata_d[RX_SEL_BIT] = rxSelect_q;
					end
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			payloadTwo_q  <= RESET_PAYLOAD;
			payloadOne_q  <= RESET_PAYLOAD;
			payloadZero_q <= RESET_PAYLOAD;
			fastRate_q    <= fast_rate_type'(RESET_FAST_RATE[5:0]);
			fineTrim_q    <= RESET_FINE_TRIM;
			coarseTrim_q  <= RESET_COARSE;
			rxSelect_q    <= 1'b0;
			rdata_q       <= 8'h00;
		end else begin
			payloadTwo_q  <= payloadTwo_d;
			payloadOne_q  <= payloadOne_d;
			payloadZero_q <= payloadZero_d;
			fastRate_q    <= fastRate_d;
			fineTrim_q    <= fineTrim_d;
			coarseTrim_q  <= coarseTrim_d;
			rxSelect_q    <= rxSelect_d;
			rdata_q       <= rdata_d;
		end
	end

	filter_time_decode filterDecode (
		.code       (fastRate_q.dominantFilterTime),
		.timeNs     (dominantFilterNs),
		.timeCycles (dominantFilterCycles)
	);

	assign rdata    = rdata_q;
	assign fastRate = fastRate_q;

	// The counter is only held off during selective wake and only in tolerant mode.
	assign errorCounterRun = !(selectiveWakeActive && fastRate_q.errorCounterDisable
		&& fastRate_q.tolerantModeEnable);

	assign analogFilterBypass  = fastRate_q.analogFilterBypass;
	// The digital filter sits outside the analog path and is never bypassed.
	assign digitalFilterActive = 1'b1;

	// Fine trim is the low five bits; a higher code gives a faster oscillator.
	assign fineTrimStep   = fineTrim_q[FINE_MSB:0];
	assign oscillatorTrim = {coarseTrim_q, fineTrim_q};

	assign wakeReceiverSelect = rxSelect_q;

	// Byte zero is the first data byte the comparator checks.
	assign referencePayload = {payloadTwo_q, payloadOne_q, payloadZero_q};
endmodule : selective_wake_config_regs

// *** tb/selective_wake_config_regs_monitor.sv ***
// Checker for the selective wake configuration registers.
// Sees only the top ports and is bound from the testbench top file.
`timescale 1ns/1ps
module selective_wake_config_regs_monitor
	import swk_cfg_pkg::*;
(
	input wire logic                       clk,
	input wire logic                       reset_n,
	input wire swk_cfg_pkg::reg_req_type   regReq,
	input wire logic [DATA_W-1:0]          rdata,
	input wire logic [1:0]                 trimEnable,
	input wire logic                       silenceTimeout,
	input wire logic                       selectiveWakeActive,
	input wire swk_cfg_pkg::fast_rate_type fastRate,
	input wire logic                       errorCounterRun,
	input wire logic                       digitalFilterActive,
	input wire logic [8:0]                 dominantFilterNs,
	input wire logic [12:0]                oscillatorTrim,
	input wire logic [4:0]                 fineTrimStep,
	input wire logic                       wakeReceiverSelect,
	input wire logic [23:0]                referencePayload
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	err_run_a:
	assert property (errorCounterRun == !(selectiveWakeActive && fastRate.errorCounterDisable
		&& fastRate.tolerantModeEnable)) else $error("error counter gating wrong");
	timeout_clr_a:
	assert property (silenceTimeout |=> !fastRate.errorCounterDisable) else $error("no clear");
	filt_ns_a:
	assert property (dominantFilterNs == ((fastRate.dominantFilterTime == FILT_LONG_CODE) ?
		FILT_LONG_NS : (fastRate.dominantFilterTime + 1) * FILT_STEP_NS)) else $error("filter ns");
	dig_filt_a:
	assert property (digitalFilterActive) else $error("digital filter off");
	trim_lock_a:
	assert property (trimEnable != TRIM_UNLOCK |=> $stable(oscillatorTrim)
		&& $stable(wakeReceiverSelect)) else $error("trim changed while locked");
	fine_step_a:
	assert property (fineTrimStep == oscillatorTrim[FINE_MSB:0]) else $error("fine step");
	pay_wr_a:
	assert property (regReq.wr && regReq.addr == OFFS_PAYLOAD_ZERO |=>
		referencePayload[7:0] == $past(regReq.wdata)) else $error("payload write lost");
	rd_idle_a:
	assert property (!regReq.rd |=> rdata == 8'h00) else $error("read data not idle");
	rsv_rd_a:
	assert property (regReq.rd && regReq.addr == OFFS_FAST_RATE |=> rdata[7:6] == 2'h0)
		else $error("reserved bits read one");
endmodule : selective_wake_config_regs_monitor

// *** tb/selective_wake_config_regs_tb.sv ***
// Random register traffic against a byte-array model of the registers.
// Assumes the design package; inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ps
module selective_wake_config_regs_tb;
	import swk_cfg_pkg::*;
	logic          clk, reset_n, silenceTimeout, selWake, w, r;
	logic          errRun, digAct, bypass, wakeSel;
	reg_req_type   regReq;
	fast_rate_type fastRate;
	logic [1:0]    trimEnable;
	logic [6:0]    a, filtCyc, tbl [0:6];
	logic [7:0]    rdata, expRd, f, m [0:127];
	logic [8:0]    filtNs;
	logic [12:0]   oscTrim;
	logic [4:0]    fineStep;
	logic [23:0]   refPay;
	int            err_total, num_checks, i, ns;
	selective_wake_config_regs u_dut (.clk(clk), .reset_n(reset_n), .regReq(regReq),
		.rdata(rdata), .trimEnable(trimEnable), .silenceTimeout(silenceTimeout),
		.selectiveWakeActive(selWake), .fastRate(fastRate), .errorCounterRun(errRun),
		.analogFilterBypass(bypass), .digitalFilterActive(digAct), .dominantFilterNs(filtNs),
		.dominantFilterCycles(filtCyc), .oscillatorTrim(oscTrim), .fineTrimStep(fineStep),
		.wakeReceiverSelect(wakeSel), .referencePayload(refPay));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", nm, ex, got);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		i = $urandom(50144);
		tbl = '{7'h31, 7'h32, 7'h33, 7'h34, 7'h38, 7'h39, 7'h35};
		err_total = 0;
		num_checks = 0;
		reset_n = 1'b0;
		regReq = '0;
		trimEnable = 2'h0;
		silenceTimeout = 1'b0;
		selWake = 1'b0;
		for (i = 0; i < 128; i++) m[i] = 8'h00;
		m[56] = RESET_FINE_TRIM;
		m[57] = {3'h0, RESET_COARSE};
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		for (i = 0; i < 4000; i++) begin
			@(posedge clk);
			// The model takes exactly what the design samples at this edge.
			expRd = regReq.rd ? m[regReq.addr] : 8'h00;
			if (regReq.rd && regReq.addr == 7'h39 && trimEnable != 2'h3) expRd[7] = 1'b0;
			if (regReq.wr) begin
				case (regReq.addr)
					7'h31, 7'h32, 7'h33: m[regReq.addr] = regReq.wdata;
					7'h34: m[52] = regReq.wdata & 8'h3F;
					7'h38: if (trimEnable == 2'h3) m[56] = regReq.wdata;
					7'h39: if (trimEnable == 2'h3) m[57] = regReq.wdata & 8'h9F;
					default: ;
				endcase
			end
			// A timeout wins over a same-edge write of the disable bit.
			if (silenceTimeout) m[52][5] = 1'b0;
			a = (i < 7) ? tbl[i] : (($urandom % 9 == 0) ? 7'($urandom) : tbl[$urandom % 6]);
			w = i >= 7 && $urandom % 2;
			r = !w && (i < 7 || $urandom % 2);
			f = 8'($urandom);
			// Software keeps the temperature coefficient bits as they are.
			if (a == OFFS_FINE_TRIM) f[7:5] = m[56][7:5];
			// Software mostly picks the low-power receiver, but both values are exercised.
			if (a == OFFS_OPTIONS) f[7] = ($urandom % 4 != 0);
			regReq <= '{addr: a, wdata: f, wr: w, rd: r};
			trimEnable <= ($urandom % 2) ? 2'h3 : 2'($urandom);
			silenceTimeout <= $urandom % 16 == 0;
			selWake <= 1'($urandom);
			@(negedge clk);
			f = m[52];
			ns = (f[3:1] == 3'h7) ? 387 : (f[3:1] + 1) * 50;
			chk("rdata", expRd, rdata);
			chk("payload", {m[49], m[50], m[51]}, refPay);
			chk("fastRate", {f[0], f[3:1], f[4], f[5]}, fastRate);
			chk("trim", {m[57][4:0], m[56]}, oscTrim);
			chk("rxSel", m[57][7], wakeSel);
			chk("errRun", !(selWake && f[5] && f[0]), errRun);
			chk("filtNs", ns, filtNs);
			chk("filtCyc", (ns + 7) / 8, filtCyc);
			chk("bypass", {1'b1, f[4]}, {digAct, bypass});
			chk("fine", m[56][4:0], fineStep);
		end
		print_verdict();
	end
endmodule : selective_wake_config_regs_tb
bind selective_wake_config_regs selective_wake_config_regs_monitor u_mon (.clk(clk),
	.reset_n(reset_n), .regReq(regReq), .rdata(rdata), .trimEnable(trimEnable),
	.silenceTimeout(silenceTimeout), .selectiveWakeActive(selectiveWakeActive),
	.fastRate(fastRate), .errorCounterRun(errorCounterRun),
	.digitalFilterActive(digitalFilterActive), .dominantFilterNs(dominantFilterNs),
	.oscillatorTrim(oscillatorTrim), .fineTrimStep(fineTrimStep),
	.wakeReceiverSelect(wakeReceiverSelect), .referencePayload(referencePayload));
